// [data_memory_checker.sv]
/*
 * port checker for the sectored data memory, bound to its top module.
 * assumes one clock domain and the synchronous reset srst.
 */
`timescale 1ns/10ps
module data_memory_checker (
    input wire logic                      clk,
    input wire logic                      srst,
    input wire data_memory_pkg::mem_req_t req,
    input wire data_memory_pkg::mem_rsp_t rsp,
    input wire logic                      sfr_rd,
    input wire logic                      sfr_wr,
    input wire logic [10:0]               sfr_addr,
    input wire logic [7:0]                sfr_rdata,
    input wire logic                      sfr_hit,
    input wire logic                      sfr_read_only
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_answer_one_cycle: assert property ((req.rd || req.wr) |=> rsp.valid)
        else $error("missing answer");
    chk_no_stray_answer: assert property (!(req.rd || req.wr) |=> !rsp.valid && rsp.rdata == 8'h00)
        else $error("answer without request");
    chk_direct_no_pointer: assert property ((req.rd || req.wr) && req.addr[10:8] != 3'h0
        |=> rsp.eff_addr == $past(req.addr)) else $error("direct address altered");
    chk_port_zero_sector: assert property (req.rd && req.addr == 11'h000 |=> rsp.eff_addr[10:8] == 3'h0)
        else $error("port zero left sector 0");
    chk_gp_not_outside: assert property ((req.rd || req.wr) && req.addr[7] && req.addr[10:8] != 3'h0
        |=> !sfr_rd && !sfr_wr) else $error("storage access sent outside");
    chk_read_only_kept: assert property (req.wr && sfr_read_only |=> !sfr_wr)
        else $error("read-only register written");
    chk_absent_reads_zero: assert property (req.rd && req.addr[10:8] != 3'h0 && !req.addr[7] && !sfr_hit
        |=> rsp.rdata == 8'h00 && !sfr_rd) else $error("absent register not zero");
    chk_outside_read_data: assert property (req.rd && req.addr[10:8] != 3'h0 && !req.addr[7] && sfr_hit
        |=> sfr_rd && rsp.rdata == $past(sfr_rdata)) else $error("outside read data wrong");
    chk_strobe_address: assert property ((sfr_rd || sfr_wr) |-> sfr_addr == rsp.eff_addr)
        else $error("strobe address differs");
endmodule : data_memory_checker
bind sectored_data_memory_indirect data_memory_checker chk (.clk, .srst, .req, .rsp, .sfr_rd, .sfr_wr,
    .sfr_addr, .sfr_rdata, .sfr_hit, .sfr_read_only);

// [data_memory_pkg.sv]
/*
 * package for the sectored data memory: pointer offsets, address layout,
 * request and answer carriers.
 * assumes one clock domain shared with the instruction core.
 */
package data_memory_pkg;

    // ------------------------------------------------------------
    // address layout
    // ------------------------------------------------------------
    localparam int SECTOR_BITS  = 3;
    localparam int SECTORS      = 8;
    localparam int ADDR_BITS    = 11;
    localparam int GP_BITS      = 7;
    localparam logic [7:0] GP_BASE = 8'h80;

    // ------------------------------------------------------------
    // special-function offsets kept here
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_INDIRECT_PORT_ZERO = 8'h00;
    localparam logic [7:0] OFS_POINTER_ZERO       = 8'h01;
    localparam logic [7:0] OFS_INDIRECT_PORT_ONE  = 8'h02;
    localparam logic [7:0] OFS_POINTER_ONE_LOW    = 8'h03;
    localparam logic [7:0] OFS_POINTER_ONE_SECTOR = 8'h04;
    localparam logic [7:0] OFS_INDIRECT_PORT_TWO  = 8'h0c;
    localparam logic [7:0] OFS_POINTER_TWO_LOW    = 8'h0d;
    localparam logic [7:0] OFS_POINTER_TWO_SECTOR = 8'h0e;

    localparam logic [7:0] POINTER_RESET = 8'h00;

    // ------------------------------------------------------------
    // access operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR
    } mem_op_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        mem_op_t     op;
        logic [2:0]  bit_sel;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
        logic [10:0] eff_addr;
    } mem_rsp_t;

endpackage : data_memory_pkg

// [sectored_data_memory_indirect.sv]
/*
 * sectored data memory with pointer-based indirect access.
 * assumes the core issues at most one access per cycle on req and
 * takes the answer one cycle later on rsp; outside special-function
 * registers are served by others on sfr_* and their data returns on
 * sfr_rdata in the same cycle as the request.
 */
`timescale 1ns/10ps

module sectored_data_memory_indirect #(
    parameter int SECTORS = data_memory_pkg::SECTORS
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire data_memory_pkg::mem_req_t req,
    output data_memory_pkg::mem_rsp_t      rsp,
    output logic                           sfr_rd,
    output logic                           sfr_wr,
    output logic [10:0]                    sfr_addr,
    output logic [7:0]                     sfr_wdata,
    input  wire logic [7:0]                sfr_rdata,
    input  wire logic                      sfr_hit,
    input  wire logic                      sfr_read_only
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] gp_ram [0:SECTORS*128-1];
    logic [7:0] pointer_zero;
    logic [7:0] pointer_one_low;
    logic [7:0] pointer_one_sector;
    logic [7:0] pointer_two_low;
    logic [7:0] pointer_two_sector;

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    logic [7:0]  req_sector;
    logic [7:0]  req_low;
    logic        is_port_zero;
    logic        is_port_one;
    logic        is_port_two;
    logic [7:0]  eff_sector;
    logic [7:0]  eff_low;
    logic        eff_ok;
    logic [10:0] eff_addr;

    always_comb begin
        // 11-bit address, sector in top bits, offset in low byte; no bank pointer
        req_sector   = {5'b0_0000, req.addr[10:8]};
        req_low      = req.addr[7:0];
        is_port_zero = (req_sector == 8'h00) && (req_low == data_memory_pkg::OFS_INDIRECT_PORT_ZERO);
        is_port_one  = (req_sector == 8'h00) && (req_low == data_memory_pkg::OFS_INDIRECT_PORT_ONE);
        is_port_two  = (req_sector == 8'h00) && (req_low == data_memory_pkg::OFS_INDIRECT_PORT_TWO);
        eff_sector   = req_sector;
        eff_low      = req_low;
        eff_ok       = 1'b1;
        if (is_port_zero) begin
            eff_sector = 8'h00;
            eff_low    = pointer_zero;
        end else if (is_port_one) begin
            eff_sector = pointer_one_sector;
            eff_low    = pointer_one_low;
        end else if (is_port_two) begin
            eff_sector = pointer_two_sector;
            eff_low    = pointer_two_low;
        end
        if (eff_sector >= 8'(SECTORS)) begin
            eff_ok = 1'b0;
        end
        eff_addr = {eff_sector[2:0], eff_low};
    end

    // a pointer pointing back at a port resolves to that port: no storage
    logic eff_is_port;
    logic eff_is_pointer;
    logic eff_is_gp;
    logic eff_is_sfr;

    always_comb begin
        eff_is_port = (eff_sector == 8'h00)
                   && (eff_low == data_memory_pkg::OFS_INDIRECT_PORT_ZERO
                    || eff_low == data_memory_pkg::OFS_INDIRECT_PORT_ONE
                    || eff_low == data_memory_pkg::OFS_INDIRECT_PORT_TWO);
        eff_is_pointer = (eff_sector == 8'h00)
                   && (eff_low == data_memory_pkg::OFS_POINTER_ZERO
                    || eff_low == data_memory_pkg::OFS_POINTER_ONE_LOW
                    || eff_low == data_memory_pkg::OFS_POINTER_ONE_SECTOR
                    || eff_low == data_memory_pkg::OFS_POINTER_TWO_LOW
                    || eff_low == data_memory_pkg::OFS_POINTER_TWO_SECTOR);
        eff_is_gp  = eff_ok && (eff_low >= data_memory_pkg::GP_BASE);
        eff_is_sfr = eff_ok && !eff_is_gp && !eff_is_port && !eff_is_pointer;
    end

    // ------------------------------------------------------------
    // current contents of the resolved location
    // ------------------------------------------------------------
    logic [7:0] cur_data;
    logic [9:0] gp_index;

    always_comb begin
        gp_index = {eff_sector[2:0], eff_low[6:0]};
        cur_data = 8'h00;
        if (!eff_ok || eff_is_port) begin
            cur_data = 8'h00;
        end else if (eff_is_gp) begin
            cur_data = gp_ram[gp_index];
        end else if (eff_is_pointer) begin
            case (eff_low)
                data_memory_pkg::OFS_POINTER_ZERO:       cur_data = pointer_zero;
                data_memory_pkg::OFS_POINTER_ONE_LOW:    cur_data = pointer_one_low;
                data_memory_pkg::OFS_POINTER_ONE_SECTOR: cur_data = pointer_one_sector;
                data_memory_pkg::OFS_POINTER_TWO_LOW:    cur_data = pointer_two_low;
                data_memory_pkg::OFS_POINTER_TWO_SECTOR: cur_data = pointer_two_sector;
                default:                                 cur_data = 8'h00;
            endcase
        end else if (sfr_hit) begin
            cur_data = sfr_rdata;
        end else begin
            cur_data = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // write value: plain or single-bit modify
    // ------------------------------------------------------------
    logic [7:0] next_data;
    logic       do_write;

    always_comb begin
        do_write  = req.wr && eff_ok && !eff_is_port;
        next_data = req.wdata;
        case (req.op)
            data_memory_pkg::OP_WRITE:     next_data = req.wdata;
            data_memory_pkg::OP_BIT_SET:   next_data = cur_data | (8'h01 << req.bit_sel);
            data_memory_pkg::OP_BIT_CLEAR: next_data = cur_data & ~(8'h01 << req.bit_sel);
            default:                       next_data = req.wdata;
        endcase
    end

    // ------------------------------------------------------------
    // general-purpose ram
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (do_write && eff_is_gp) begin
            gp_ram[gp_index] <= next_data;
        end
    end

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pointer_zero       <= data_memory_pkg::POINTER_RESET;
            pointer_one_low    <= data_memory_pkg::POINTER_RESET;
            pointer_one_sector <= data_memory_pkg::POINTER_RESET;
            pointer_two_low    <= data_memory_pkg::POINTER_RESET;
            pointer_two_sector <= data_memory_pkg::POINTER_RESET;
        end else if (do_write && eff_is_pointer) begin
            case (eff_low)
                data_memory_pkg::OFS_POINTER_ZERO:       pointer_zero       <= next_data;
                data_memory_pkg::OFS_POINTER_ONE_LOW:    pointer_one_low    <= next_data;
                data_memory_pkg::OFS_POINTER_ONE_SECTOR: pointer_one_sector <= next_data;
                data_memory_pkg::OFS_POINTER_TWO_LOW:    pointer_two_low    <= next_data;
                data_memory_pkg::OFS_POINTER_TWO_SECTOR: pointer_two_sector <= next_data;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outside special-function strobes, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sfr_rd    <= 1'b0;
            sfr_wr    <= 1'b0;
            sfr_addr  <= 11'h000;
            sfr_wdata <= 8'h00;
        end else begin
            sfr_rd    <= 1'b0;
            sfr_wr    <= do_write && eff_is_sfr && sfr_hit && !sfr_read_only;
            sfr_addr  <= eff_addr;
            sfr_wdata <= next_data;
            if (req.rd && eff_is_sfr && sfr_hit) begin
                sfr_rd <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // answer to the core
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp <= '0;
        end else begin
            rsp.valid    <= req.rd || req.wr;
            rsp.rdata    <= req.rd ? cur_data : 8'h00;
            rsp.eff_addr <= eff_addr;
        end
    end

endmodule : sectored_data_memory_indirect

// [sectored_data_memory_indirect_bench.sv]
/*
 * self-checking bench for the sectored data memory with a reference model.
 * assumes the outside register model and the checker are compiled first.
 */
`timescale 1ns/10ps
module sectored_data_memory_indirect_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    data_memory_pkg::mem_req_t req = '0;
    data_memory_pkg::mem_rsp_t rsp;
    logic sfr_rd, sfr_wr, sfr_hit, sfr_read_only;
    logic [10:0] sfr_addr;
    logic [7:0] sfr_wdata, sfr_rdata;
    int num_errors = 0;
    int checks_done = 0;
    int mem[int];
    int sfr_reg = 0;
    int ptrs[5] = '{1, 3, 4, 13, 14};
    always #25 clk = ~clk;
    sectored_data_memory_indirect dut (.clk, .srst, .req, .rsp, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata,
        .sfr_rdata, .sfr_hit, .sfr_read_only);
    sfr_side_model side (.clk, .srst, .addr(req.addr), .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata,
        .sfr_hit, .sfr_read_only);
    task check(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // resolved address, -1 when the access is dropped
    function int res(input int a);
        int o;
        int s;
        o = a % 256;
        if (a < 256 && (o == 0 || o == 2 || o == 12)) begin
            s = o == 0 ? 0 : (o == 2 ? mem[4] : mem[14]);
            o = o == 0 ? mem[1] : (o == 2 ? mem[3] : mem[13]);
            if (s > 7 || (s == 0 && (o == 0 || o == 2 || o == 12))) return -1;
            a = s * 256 + o;
        end
        return a;
    endfunction : res
    function int peek(input int e);
        if (e < 0) return 0;
        if (mem.exists(e)) return mem[e];
        return e == 'h140 ? sfr_reg : (e == 'h141 ? 'h5a : 0);
    endfunction : peek
    task acc(input logic rd, input logic wr, input data_memory_pkg::mem_op_t op, input logic [2:0] b,
             input logic [10:0] a, input logic [7:0] d);
        int e;
        int old;
        int nv;
        e = res(a);
        old = peek(e);
        nv = op == data_memory_pkg::OP_WRITE ? d : (op == data_memory_pkg::OP_BIT_SET ? old | (1 << b)
            : old & ~(1 << b));
        @(posedge clk) #1;
        req = '{rd, wr, op, b, a, d};
        @(posedge clk) #1;
        req = '0;
        check(rsp.valid, 11'h001);
        check(rsp.rdata, rd ? 11'(old) : 11'h000);
        if (rd && e >= 0) check(rsp.eff_addr, 11'(e));
        if (wr && e >= 0 && (e % 256 >= 128 || (e < 256 && mem.exists(e)))) mem[e] = nv % 256;
        if (wr && e == 'h140) sfr_reg = nv % 256;
    endtask : acc
    task rd(input logic [10:0] a);
        acc(1'b1, 1'b0, data_memory_pkg::OP_WRITE, 3'h0, a, 8'h00);
    endtask : rd
    task wr(input logic [10:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, data_memory_pkg::OP_WRITE, 3'h0, a, d);
    endtask : wr
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        int a;
        a = $urandom(32'hf1f4);
        foreach (ptrs[i]) mem[ptrs[i]] = 0;
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        foreach (ptrs[i]) rd(11'(ptrs[i]));
        foreach (ptrs[i]) wr(11'(ptrs[i]), 8'(8'h80 + i));
        acc(1'b0, 1'b1, data_memory_pkg::OP_BIT_SET, 3'h6, 11'h001, 8'h00);
        foreach (ptrs[i]) rd(11'(ptrs[i]));
        $display("pointer test done");
        for (int i = 0; i < 16; i++) begin
            a = (i % 8) * 256 + 128 + $urandom % 128;
            wr(11'(a), 8'($urandom));
            rd(11'(a));
        end
        $display("direct test done");
        wr(11'h001, 8'h9c);
        wr(11'h000, 8'h3c);
        rd(11'h09c);
        rd(11'h000);
        wr(11'h003, 8'hc0);
        wr(11'h00d, 8'he0);
        for (int s = 0; s < 9; s++) begin
            wr(11'h004, 8'(s));
            wr(11'h00e, 8'(s));
            wr(11'h002, 8'(s + 1));
            wr(11'h00c, 8'(s + 9));
            rd(11'h002);
            rd(11'h00c);
            rd(11'((s % 8) * 256 + 'hc0));
            rd(11'((s % 8) * 256 + 'he0));
        end
        $display("indirect test done");
        wr(11'h001, 8'h02);
        wr(11'h000, 8'h55);
        rd(11'h000);
        wr(11'h3a5, 8'h0f);
        for (int b = 0; b < 8; b++) begin
            acc(1'b0, 1'b1, b % 2 ? data_memory_pkg::OP_BIT_CLEAR : data_memory_pkg::OP_BIT_SET, 3'(b),
                11'h3a5, 8'h00);
            rd(11'h3a5);
        end
        $display("bit test done");
        wr(11'h140, 8'h66);
        rd(11'h140);
        wr(11'h141, 8'h11);
        rd(11'h141);
        rd(11'h150);
        wr(11'h00b, 8'h01);
        rd(11'h3a5);
        rd(11'h17f);
        $display("outside register test done");
        finish_test;
    end
endmodule : sectored_data_memory_indirect_bench

// [sfr_side_model.sv]
/*
 * outside register model: one read-write register at 140H, one read-only at 141H.
 * assumes direct addresses only are aimed at it.
 */
`timescale 1ns/10ps
module sfr_side_model #(
    parameter logic [7:0] RO_VALUE = 8'h5a
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [10:0] addr,
    input  wire logic        sfr_wr,
    input  wire logic [10:0] sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    output logic             sfr_hit,
    output logic             sfr_read_only
);
    logic [7:0] rw_reg;
    always_ff @(posedge clk) begin
        if (srst) rw_reg <= 8'h00;
        else if (sfr_wr && sfr_addr == 11'h140) rw_reg <= sfr_wdata;
    end
    assign sfr_hit = addr == 11'h140 || addr == 11'h141;
    assign sfr_read_only = addr == 11'h141;
    // absent places show a changing value
    assign sfr_rdata = addr == 11'h140 ? rw_reg : (addr == 11'h141 ? RO_VALUE : ~rw_reg);
endmodule : sfr_side_model
